// ### common/tdc_pkg.sv
`default_nettype none

package tdc_pkg;

    // -------------------------------------------------------------------
    // Clock and increment reset values
    // -------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS   = 8000;   // 125 MHz register and counter clock
    localparam int unsigned PS_PER_NS       = 1000;
    localparam int unsigned FRAC_ONE        = 65536;  // One nanosecond in fraction units
    localparam logic [3:0]  INC_WHOLE_DEF   = 4'(CLK_PERIOD_PS / PS_PER_NS);
    localparam logic [15:0] INC_FRAC_DEF    =
        16'(((CLK_PERIOD_PS % PS_PER_NS) * FRAC_ONE) / PS_PER_NS);
    localparam int unsigned STEP_NS_RST_DEF = 6;      // Offset step whole ns after reset
    localparam logic [15:0] STEP_FNS_RST    = 16'h0000;
    localparam logic [19:0] STEP_CNT_RST    = 20'h00000;
    localparam logic [3:0]  DRIFT_NS_RST    = 4'h0;
    localparam logic [15:0] DRIFT_FNS_RST   = 16'h0000;
    localparam logic [15:0] RATE_RST        = 16'h0000;
    localparam logic [15:0] SEC_HI_RST      = 16'h0000;
    localparam logic [31:0] SEC_LO_RST      = 32'h00000000;
    localparam logic [31:0] NS_RST          = 32'h00000000;
    localparam logic [15:0] FRAC_RST        = 16'h0000;
    localparam logic [31:0] NS_PER_SEC      = 32'h3b9aca00; // One billion

    // -------------------------------------------------------------------
    // Register word offsets
    // -------------------------------------------------------------------
    localparam int unsigned ADDR_W      = 6;
    localparam logic [5:0]  OFS_SEC_HI  = 6'h00;
    localparam logic [5:0]  OFS_SEC_LO  = 6'h01;
    localparam logic [5:0]  OFS_NS      = 6'h02;
    localparam logic [5:0]  OFS_RSVD    = 6'h03;
    localparam logic [5:0]  OFS_PERIOD  = 6'h04;
    localparam logic [5:0]  OFS_STEP    = 6'h05;
    localparam logic [5:0]  OFS_STEP_N  = 6'h06;
    localparam logic [5:0]  OFS_DRIFT   = 6'h1c;
    localparam logic [5:0]  OFS_RATE    = 6'h20;

    // -------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------
    localparam int unsigned FRAC_LSB    = 0;
    localparam int unsigned FRAC_MSB    = 15;
    localparam int unsigned WHOLE_LSB   = 16;
    localparam int unsigned WHOLE_MSB   = 19;
    localparam int unsigned SEC_HI_MSB  = 15;
    localparam int unsigned STEP_N_MSB  = 19;
    localparam int unsigned RATE_MSB    = 15;

endpackage : tdc_pkg

`default_nettype wire

// ### logic/tdc_interval_tick.sv
`timescale 1ns/1ps
`default_nettype none

module tdc_interval_tick #(
    parameter int unsigned W = 16
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    // Interval in cycles, zero stops the ticks
    input  wire logic [W-1:0] interval,
    // One-cycle tick at the end of each interval
    output logic              tick
);

    // -------------------------------------------------------------------
    // Elaboration check
    // -------------------------------------------------------------------
    if (W < 1 || W > 31) begin : g_bad_w
        $error("tdc_interval_tick: width out of range");
    end

    // -------------------------------------------------------------------
    // Cycle counter
    // -------------------------------------------------------------------
    logic [W-1:0] cnt_ff, nxt_cnt;

    // Tick on the last cycle of the interval, also if it was shortened
    always_comb begin
        tick    = (interval != '0) && (cnt_ff >= W'(interval - 1'b1));
        nxt_cnt = tick ? '0 : W'(cnt_ff + 1'b1);
        if (interval == '0) begin
            nxt_cnt = '0;
        end
    end

    // Register the count
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    a_tick_spacing: assert property (
        @(posedge mclk) disable iff (rst)
        (interval != '0 && !tick && $stable(interval)) |=> (cnt_ff == W'($past(cnt_ff) + 1'b1))
    ) else $error("interval counter did not advance");

endmodule : tdc_interval_tick

`default_nettype wire

// ### logic/tdc_regs.sv
`timescale 1ns/1ps
`default_nettype none

module tdc_regs
    import tdc_pkg::*;
#(
    parameter int unsigned offset_step_ns_reset_param = STEP_NS_RST_DEF,
    parameter int unsigned INC_NS_RESET               = int'(INC_WHOLE_DEF),
    parameter int unsigned INC_FRAC_RESET             = int'(INC_FRAC_DEF)
) (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              rst,
    // Register control port
    input  wire logic [ADDR_W-1:0] csr_address,
    input  wire logic              csr_read,
    input  wire logic              csr_write,
    input  wire logic [31:0]       csr_writedata,
    output logic      [31:0]       csr_readdata
);

    // -------------------------------------------------------------------
    // Elaboration checks
    // -------------------------------------------------------------------
    if (offset_step_ns_reset_param > 15 || INC_NS_RESET > 15) begin : g_bad_ns
        $error("tdc_regs: whole nanosecond reset value exceeds four bits");
    end
    if (INC_FRAC_RESET > 65535) begin : g_bad_frac
        $error("tdc_regs: fraction reset value exceeds sixteen bits");
    end

    localparam logic [3:0]  STEP_NS_RST = 4'(offset_step_ns_reset_param);
    localparam logic [3:0]  INC_NS_RST  = 4'(INC_NS_RESET);
    localparam logic [15:0] INC_FNS_RST = 16'(INC_FRAC_RESET);

    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    logic [15:0] seconds_high_ff,          nxt_seconds_high;
    logic [31:0] seconds_low_ff,           nxt_seconds_low;
    logic [31:0] subsecond_count_ff,       nxt_subsecond_count;
    logic [15:0] frac_ff,                  nxt_frac;
    logic [3:0]  increment_whole_ns_ff,    nxt_increment_whole_ns;
    logic [15:0] increment_fraction_ff,    nxt_increment_fraction;
    logic [3:0]  offset_step_whole_ns_ff,  nxt_offset_step_whole_ns;
    logic [15:0] offset_step_fraction_ff,  nxt_offset_step_fraction;
    logic [19:0] offset_step_cycles_ff,    nxt_offset_step_cycles;
    logic [3:0]  drift_whole_ns_ff,        nxt_drift_whole_ns;
    logic [15:0] drift_fraction_ff,        nxt_drift_fraction;
    logic [15:0] drift_interval_cycles_ff, nxt_drift_interval_cycles;
    logic [31:0] nxt_readdata;

    // -------------------------------------------------------------------
    // Write strobes
    // -------------------------------------------------------------------
    logic wr_sec_hi;
    logic wr_sec_lo;
    logic wr_ns;
    logic wr_period;
    logic wr_step;
    logic wr_step_n;
    logic wr_drift;
    logic wr_rate;

    // One strobe per mapped word; the reserved word has none
    always_comb begin
        wr_sec_hi = csr_write && (csr_address == OFS_SEC_HI);
        wr_sec_lo = csr_write && (csr_address == OFS_SEC_LO);
        wr_ns     = csr_write && (csr_address == OFS_NS);
        wr_period = csr_write && (csr_address == OFS_PERIOD);
        wr_step   = csr_write && (csr_address == OFS_STEP);
        wr_step_n = csr_write && (csr_address == OFS_STEP_N);
        wr_drift  = csr_write && (csr_address == OFS_DRIFT);
        wr_rate   = csr_write && (csr_address == OFS_RATE);
    end

    // -------------------------------------------------------------------
    // Increment selection and time arithmetic
    // -------------------------------------------------------------------
    logic        step_active;
    logic        drift_hit;
    logic [3:0]  cur_inc_ns;
    logic [15:0] cur_inc_frac;
    logic [3:0]  drift_add_ns;
    logic [15:0] drift_add_frac;
    logic [47:0] step_sec;
    logic [31:0] step_ns;
    logic [15:0] step_frac;
    logic [47:0] sum_sec;
    logic [31:0] sum_ns;
    logic [15:0] sum_frac;

    // Alternate step replaces the period while cycles remain
    always_comb begin
        step_active    = (offset_step_cycles_ff != STEP_CNT_RST);
        cur_inc_ns     = step_active ? offset_step_whole_ns_ff : increment_whole_ns_ff;
        cur_inc_frac   = step_active ? offset_step_fraction_ff : increment_fraction_ff;
        drift_add_ns   = drift_hit ? drift_whole_ns_ff : 4'h0;
        drift_add_frac = drift_hit ? drift_fraction_ff : 16'h0000;
    end

    // Normal or alternate per-cycle step
    tdc_tod_add u_step_add (
        .sec_in   ({seconds_high_ff, seconds_low_ff}),
        .ns_in    (subsecond_count_ff),
        .frac_in  (frac_ff),
        .inc_ns   (cur_inc_ns),
        .inc_frac (cur_inc_frac),
        .sec_out  (step_sec),
        .ns_out   (step_ns),
        .frac_out (step_frac)
    );

    // Drift correction on top of the step
    tdc_tod_add u_drift_add (
        .sec_in   (step_sec),
        .ns_in    (step_ns),
        .frac_in  (step_frac),
        .inc_ns   (drift_add_ns),
        .inc_frac (drift_add_frac),
        .sec_out  (sum_sec),
        .ns_out   (sum_ns),
        .frac_out (sum_frac)
    );

    // Correction interval timer
    tdc_interval_tick #(
        .W (RATE_MSB + 1)
    ) u_drift_tick (
        .mclk     (mclk),
        .rst      (rst),
        .interval (drift_interval_cycles_ff),
        .tick     (drift_hit)
    );

    // -------------------------------------------------------------------
    // Time of day next state
    // -------------------------------------------------------------------
    // A software write to a time word wins over the advance of that word
    always_comb begin
        nxt_seconds_high    = sum_sec[47:32];
        nxt_seconds_low     = sum_sec[31:0];
        nxt_subsecond_count = sum_ns;
        nxt_frac            = sum_frac;
        if (wr_sec_hi) begin
            nxt_seconds_high = csr_writedata[SEC_HI_MSB:0];
        end
        if (wr_sec_lo) begin
            nxt_seconds_low = csr_writedata;
        end
        if (wr_ns) begin
            nxt_subsecond_count = csr_writedata;
            nxt_frac            = FRAC_RST;
        end
    end

    // -------------------------------------------------------------------
    // Configuration next state
    // -------------------------------------------------------------------
    always_comb begin
        nxt_increment_whole_ns    = increment_whole_ns_ff;
        nxt_increment_fraction    = increment_fraction_ff;
        nxt_offset_step_whole_ns  = offset_step_whole_ns_ff;
        nxt_offset_step_fraction  = offset_step_fraction_ff;
        nxt_drift_whole_ns        = drift_whole_ns_ff;
        nxt_drift_fraction        = drift_fraction_ff;
        nxt_drift_interval_cycles = drift_interval_cycles_ff;
        nxt_offset_step_cycles    = step_active ? 20'(offset_step_cycles_ff - 1'b1)
                                                : offset_step_cycles_ff;
        if (wr_period) begin
            nxt_increment_fraction = csr_writedata[FRAC_MSB:FRAC_LSB];
            nxt_increment_whole_ns = csr_writedata[WHOLE_MSB:WHOLE_LSB];
        end
        if (wr_step) begin
            nxt_offset_step_fraction = csr_writedata[FRAC_MSB:FRAC_LSB];
            nxt_offset_step_whole_ns = csr_writedata[WHOLE_MSB:WHOLE_LSB];
        end
        if (wr_step_n) begin
            nxt_offset_step_cycles = csr_writedata[STEP_N_MSB:0];
        end
        if (wr_drift) begin
            nxt_drift_fraction = csr_writedata[FRAC_MSB:FRAC_LSB];
            nxt_drift_whole_ns = csr_writedata[WHOLE_MSB:WHOLE_LSB];
        end
        if (wr_rate) begin
            nxt_drift_interval_cycles = csr_writedata[RATE_MSB:0];
        end
    end

    // -------------------------------------------------------------------
    // Read data
    // -------------------------------------------------------------------
    // Unused bits, the reserved word and unmapped words read as zero
    always_comb begin
        nxt_readdata = csr_readdata;
        if (csr_read) begin
            if (csr_address == OFS_SEC_HI) begin
                nxt_readdata = {16'h0000, seconds_high_ff};
            end else if (csr_address == OFS_SEC_LO) begin
                nxt_readdata = seconds_low_ff;
            end else if (csr_address == OFS_NS) begin
                nxt_readdata = subsecond_count_ff;
            end else if (csr_address == OFS_PERIOD) begin
                nxt_readdata = {12'h000, increment_whole_ns_ff, increment_fraction_ff};
            end else if (csr_address == OFS_STEP) begin
                nxt_readdata = {12'h000, offset_step_whole_ns_ff, offset_step_fraction_ff};
            end else if (csr_address == OFS_STEP_N) begin
                nxt_readdata = {12'h000, offset_step_cycles_ff};
            end else if (csr_address == OFS_DRIFT) begin
                nxt_readdata = {12'h000, drift_whole_ns_ff, drift_fraction_ff};
            end else if (csr_address == OFS_RATE) begin
                nxt_readdata = {16'h0000, drift_interval_cycles_ff};
            end else begin
                nxt_readdata = 32'h00000000;
            end
        end
    end

    // -------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            seconds_high_ff          <= SEC_HI_RST;
            seconds_low_ff           <= SEC_LO_RST;
            subsecond_count_ff       <= NS_RST;
            frac_ff                  <= FRAC_RST;
            increment_whole_ns_ff    <= INC_NS_RST;
            increment_fraction_ff    <= INC_FNS_RST;
            offset_step_whole_ns_ff  <= STEP_NS_RST;
            offset_step_fraction_ff  <= STEP_FNS_RST;
            offset_step_cycles_ff    <= STEP_CNT_RST;
            drift_whole_ns_ff        <= DRIFT_NS_RST;
            drift_fraction_ff        <= DRIFT_FNS_RST;
            drift_interval_cycles_ff <= RATE_RST;
            csr_readdata             <= 32'h00000000;
        end else begin
            seconds_high_ff          <= nxt_seconds_high;
            seconds_low_ff           <= nxt_seconds_low;
            subsecond_count_ff       <= nxt_subsecond_count;
            frac_ff                  <= nxt_frac;
            increment_whole_ns_ff    <= nxt_increment_whole_ns;
            increment_fraction_ff    <= nxt_increment_fraction;
            offset_step_whole_ns_ff  <= nxt_offset_step_whole_ns;
            offset_step_fraction_ff  <= nxt_offset_step_fraction;
            offset_step_cycles_ff    <= nxt_offset_step_cycles;
            drift_whole_ns_ff        <= nxt_drift_whole_ns;
            drift_fraction_ff        <= nxt_drift_fraction;
            drift_interval_cycles_ff <= nxt_drift_interval_cycles;
            csr_readdata             <= nxt_readdata;
        end
    end

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    a_sec_high_read: assert property (
        @(posedge mclk) disable iff (rst)
        (csr_read && csr_address == OFS_SEC_HI)
            |=> (csr_readdata == {16'h0000, $past(seconds_high_ff)})
    ) else $error("seconds high word read back wrong");

    a_time_reset: assert property (
        @(posedge mclk)
        rst |=> (seconds_low_ff == SEC_LO_RST && subsecond_count_ff == NS_RST
                 && seconds_high_ff == SEC_HI_RST)
    ) else $error("time of day not cleared by reset");

    a_ns_write: assert property (
        @(posedge mclk) disable iff (rst)
        wr_ns ##1 (csr_read && csr_address == OFS_NS && !csr_write)
            |=> (csr_readdata == $past(csr_writedata, 2))
    ) else $error("nanosecond word lost a write");

    a_rsvd_read: assert property (
        @(posedge mclk) disable iff (rst)
        (csr_read && csr_address == OFS_RSVD) |=> (csr_readdata == 32'h00000000)
    ) else $error("reserved word read nonzero");

    a_period_write: assert property (
        @(posedge mclk) disable iff (rst)
        wr_period |=> ({increment_whole_ns_ff, increment_fraction_ff}
                       == $past(csr_writedata[WHOLE_MSB:FRAC_LSB]))
    ) else $error("period word not stored");

    a_period_reset: assert property (
        @(posedge mclk)
        rst |=> (increment_whole_ns_ff == INC_NS_RST && increment_fraction_ff == INC_FNS_RST)
    ) else $error("period word reset value wrong");

    a_ns_advance: assert property (
        @(posedge mclk) disable iff (rst)
        (!csr_write && !step_active && !drift_hit
            && subsecond_count_ff < 32'h3b9ac9f0)
            |=> ({subsecond_count_ff, frac_ff} == 48'($past({subsecond_count_ff, frac_ff})
                 + {28'h0, $past(increment_whole_ns_ff), $past(increment_fraction_ff)}))
    ) else $error("time of day did not advance by the period");

    a_ns_bounded: assert property (
        @(posedge mclk) disable iff (rst)
        ($past(!csr_write) && $past(subsecond_count_ff) < NS_PER_SEC)
            |-> (subsecond_count_ff < NS_PER_SEC)
    ) else $error("nanosecond count reached one second");

    a_step_count: assert property (
        @(posedge mclk) disable iff (rst)
        (step_active && !wr_step_n)
            |=> (offset_step_cycles_ff == 20'($past(offset_step_cycles_ff) - 1'b1))
    ) else $error("offset step count did not decrement");

    a_drift_apply: assert property (
        @(posedge mclk) disable iff (rst)
        (drift_hit && !csr_write && !step_active && subsecond_count_ff < 32'h3b9ac9e0)
            |=> ({subsecond_count_ff, frac_ff} == 48'($past({subsecond_count_ff, frac_ff})
                 + {28'h0, $past(increment_whole_ns_ff), $past(increment_fraction_ff)}
                 + {28'h0, $past(drift_whole_ns_ff), $past(drift_fraction_ff)}))
    ) else $error("drift correction not added");

    a_step_reset: assert property (
        @(posedge mclk)
        rst |=> (offset_step_whole_ns_ff == STEP_NS_RST)
    ) else $error("offset step reset value wrong");

endmodule : tdc_regs

`default_nettype wire

// ### logic/tdc_tod_add.sv
`timescale 1ns/1ps
`default_nettype none

module tdc_tod_add
    import tdc_pkg::*;
(
    // Time in
    input  wire logic [47:0] sec_in,
    input  wire logic [31:0] ns_in,
    input  wire logic [15:0] frac_in,
    // Step to add
    input  wire logic [3:0]  inc_ns,
    input  wire logic [15:0] inc_frac,
    // Time out
    output logic      [47:0] sec_out,
    output logic      [31:0] ns_out,
    output logic      [15:0] frac_out
);

    // -------------------------------------------------------------------
    // Fraction, nanosecond and second carry chain
    // -------------------------------------------------------------------
    logic [16:0] frac_sum;
    logic [32:0] ns_sum;

    always_comb begin
        frac_sum = {1'b0, frac_in} + {1'b0, inc_frac};
        ns_sum   = {1'b0, ns_in} + {29'h0, inc_ns} + {32'h0, frac_sum[16]};
        frac_out = frac_sum[15:0];
        sec_out  = sec_in;
        ns_out   = ns_sum[31:0];
        if (ns_sum >= {1'b0, NS_PER_SEC}) begin
            ns_out  = 32'(ns_sum - {1'b0, NS_PER_SEC});
            sec_out = sec_in + 48'h1;
        end
    end

endmodule : tdc_tod_add

`default_nettype wire

// ### tb/tdc_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none

module tdc_regs_bench
    import tdc_pkg::*;
;
    typedef struct packed {logic [5:0] a; logic w; logic [31:0] d; logic [31:0] e;} tdc_row_t;

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic        mclk;
    logic        rst;
    logic [5:0]  csr_address;
    logic        csr_read;
    logic        csr_write;
    logic [31:0] csr_writedata;
    logic [31:0] csr_readdata;
    logic [31:0] q;
    int          errors = 0;
    int          compares = 0;

    // Reset values, field masks and restore writes
    tdc_row_t rows [20] = '{
        '{OFS_PERIOD, 1'h0, 32'h0, 32'h00080000}, '{OFS_STEP, 1'h0, 32'h0, 32'h00060000},
        '{OFS_STEP_N, 1'h0, 32'h0, 32'h0}, '{OFS_DRIFT, 1'h0, 32'h0, 32'h0},
        '{OFS_RATE, 1'h0, 32'h0, 32'h0}, '{OFS_SEC_HI, 1'h0, 32'h0, 32'h0},
        '{OFS_SEC_LO, 1'h0, 32'h0, 32'h0},
        '{OFS_PERIOD, 1'h1, 32'hffffffff, 32'h000fffff},
        '{OFS_PERIOD, 1'h1, 32'h00080000, 32'h00080000},
        '{OFS_STEP, 1'h1, 32'hffffffff, 32'h000fffff},
        '{OFS_STEP, 1'h1, 32'h00060000, 32'h00060000},
        '{OFS_STEP_N, 1'h1, 32'hffffffff, 32'h000fffff}, '{OFS_STEP_N, 1'h1, 32'h0, 32'h0},
        '{OFS_DRIFT, 1'h1, 32'hffffffff, 32'h000fffff}, '{OFS_DRIFT, 1'h1, 32'h0, 32'h0},
        '{OFS_RATE, 1'h1, 32'hffffffff, 32'h0000ffff}, '{OFS_RATE, 1'h1, 32'h0, 32'h0},
        '{OFS_RSVD, 1'h1, 32'hffffffff, 32'h0}, '{6'h3f, 1'h1, 32'hffffffff, 32'h0},
        '{OFS_SEC_HI, 1'h1, 32'hffffffff, 32'h0000ffff}};

    tdc_regs tdc_regs_i (.mclk(mclk), .rst(rst), .csr_address(csr_address),
        .csr_read(csr_read), .csr_write(csr_write), .csr_writedata(csr_writedata),
        .csr_readdata(csr_readdata));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    // One access taken at the next edge, read data captured after it
    task acc(input logic r, input logic [5:0] a, input logic [31:0] d);
        csr_read = r;
        csr_write = !r;
        csr_address = a;
        csr_writedata = d;
        @(posedge mclk);
        #1;
        q = csr_readdata;
    endtask : acc

    task idle;
        csr_read = 1'h0;
        csr_write = 1'h0;
        @(posedge mclk);
        #1;
    endtask : idle

    task results;
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    // ----------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------------------------------
    initial begin
        mclk = 1'h0;
        forever #4 mclk = ~mclk;
    end

    initial begin
        repeat (2000) @(posedge mclk);
        errors++;
        results();
    end

    initial begin
        rst = 1'h1;
        csr_read = 1'h0;
        csr_write = 1'h0;
        csr_address = 6'h0;
        csr_writedata = 32'h0;
        repeat (10) @(posedge mclk);
        #1;
        rst = 1'h0;
        foreach (rows[i]) begin
            if (rows[i].w) acc(1'h0, rows[i].a, rows[i].d);
            acc(1'h1, rows[i].a, 32'h0);
            chk(q, rows[i].e);
        end
        // Nanoseconds wrap into both seconds words
        acc(1'h0, OFS_NS, NS_PER_SEC - 32'h18);
        acc(1'h0, OFS_SEC_HI, 32'h00001234);
        acc(1'h0, OFS_SEC_LO, 32'hffffffff);
        acc(1'h1, OFS_NS, 32'h0);
        chk(q, NS_PER_SEC - 32'h8);
        acc(1'h1, OFS_NS, 32'h0);
        chk(q, 32'h0);
        acc(1'h1, OFS_SEC_LO, 32'h0);
        chk(q, 32'h0);
        acc(1'h1, OFS_SEC_HI, 32'h0);
        chk(q, 32'h00001235);
        // Three alternate 6 ns steps, then back to 8 ns
        acc(1'h0, OFS_NS, 32'h0);
        acc(1'h0, OFS_STEP_N, 32'h3);
        for (int k = 0; k < 5; k++) begin
            acc(1'h1, OFS_NS, 32'h0);
            chk(q, (k < 4) ? 32'(8 + 6 * k) : 32'(34));
        end
        // Drift of 1.5 ns every 4 cycles over an 8 cycle span
        acc(1'h0, OFS_DRIFT, 32'h00018000);
        acc(1'h0, OFS_RATE, 32'h4);
        acc(1'h0, OFS_NS, 32'h0);
        acc(1'h1, OFS_NS, 32'h0);
        chk(q, 32'h0);
        repeat (7) idle();
        acc(1'h1, OFS_NS, 32'h0);
        chk(q, 32'h43);
        // A 7.5 ns period carries its fraction into the nanoseconds
        acc(1'h0, OFS_RATE, 32'h0);
        acc(1'h0, OFS_PERIOD, 32'h00078000);
        acc(1'h1, OFS_PERIOD, 32'h0);
        chk(q, 32'h00078000);
        acc(1'h0, OFS_NS, 32'h0);
        repeat (2) idle();
        acc(1'h1, OFS_NS, 32'h0);
        chk(q, 32'hf);
        // Reset in mid-run restores the time and configuration words
        idle();
        rst = 1'h1;
        @(posedge mclk);
        #1;
        rst = 1'h0;
        chk(csr_readdata, 32'h0);
        acc(1'h1, OFS_NS, 32'h0);
        chk(q, 32'h0);
        acc(1'h1, OFS_SEC_HI, 32'h0);
        chk(q, 32'h0);
        acc(1'h1, OFS_STEP, 32'h0);
        chk(q, 32'h00060000);
        acc(1'h1, OFS_PERIOD, 32'h0);
        chk(q, 32'h00080000);
        acc(1'h1, OFS_DRIFT, 32'h0);
        chk(q, 32'h0);
        acc(1'h1, OFS_RATE, 32'h0);
        chk(q, 32'h0);
        idle();
        results();
    end
endmodule : tdc_regs_bench

`default_nettype wire
